// *** rtl/swire_pkg.sv ***
// Shared constants and types for the single-line search and scratchpad link
package swire_pkg;

	// Clock rate and busy times
	localparam int CLK_MHZ = 50;
	localparam int COPY_TIME_US = 10000;
	localparam int TEMP_TIME_US = 10000;
	localparam int COPY_CYC = COPY_TIME_US * CLK_MHZ;
	localparam int TEMP_CYC = TEMP_TIME_US * CLK_MHZ;
	localparam int BUSY_W = 20;

	// Slot framing: cycle index within an eight-cycle slot
	localparam logic [3:0] SLOT_MID = 4'h3;
	localparam logic [3:0] SLOT_SAMPLE = 4'h6;
	localparam logic [3:0] SLOT_LAST = 4'h7;

	// Slot kinds driven by the master
	localparam logic [1:0] KIND_RESET = 2'h0;
	localparam logic [1:0] KIND_WRITE = 2'h1;
	localparam logic [1:0] KIND_READ = 2'h2;

	// Command codes
	localparam logic [7:0] CMD_SEARCH = 8'hf0;
	localparam logic [7:0] CMD_SKIP = 8'hcc;
	localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
	localparam logic [7:0] CMD_READ_SP = 8'hbe;
	localparam logic [7:0] CMD_COPY_SP = 8'h48;
	localparam logic [7:0] CMD_RECALL = 8'hb8;
	localparam logic [7:0] CMD_CONVERT_T = 8'h44;

	// Read stream positions, identity length, check polynomial
	localparam logic [3:0] BYTE_CRC = 4'h8;
	localparam logic [3:0] BYTE_ONES = 4'h9;
	localparam logic [2:0] BYTE_LAST = 3'h7;
	localparam logic [5:0] ID_LAST = 6'h3f;
	localparam logic [7:0] CRC_POLY = 8'h8c;
	// Arbitrary identity value
	localparam logic [63:0] ROM_ID_DEFAULT = 64'h5a3c_9617_e2b4_0d81;

	// Master user operations and their slot counts
	localparam logic [1:0] OP_RESET = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_TRIPLET = 2'h3;
	localparam logic [3:0] SLOTS_BYTE = 4'h8;
	localparam logic [3:0] SLOTS_TRIPLET = 4'h3;
	localparam logic [3:0] SLOTS_ONE = 4'h1;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ROM_CMD, ST_SEARCH, ST_MEM_CMD, ST_PAGE,
		ST_WRITE, ST_READ, ST_COPY_RD, ST_TEMP_RD
	} dev_state_t;

	typedef enum logic [1:0] {M_IDLE, M_SLOT, M_GAP} mst_state_t;

endpackage

// *** rtl/swire_if.sv ***
// Slot-level link between bus master and slave, with the wired-AND line
`timescale 1ns/1ns
interface swire_if;
	logic slot_active; // Master frames a slot
	logic [1:0] slot_kind; // Reset, write or read slot
	logic mst_o; // Master output value, always low
	logic mst_oe_n; // Master pulls the line while low
	logic dev_o; // Slave output value, always low
	logic dev_oe_n; // Slave pulls the line while low
	logic line; // Resolved level, idles high

	// Open drain: any enabled low driver pulls the line down
	assign line = (mst_oe_n | mst_o) & (dev_oe_n | dev_o);

	modport master(output slot_active, slot_kind, mst_o, mst_oe_n,
		input line);
	modport device(input slot_active, slot_kind, line,
		output dev_o, dev_oe_n);
endinterface

// *** rtl/search_and_scratchpad_cmds.sv ***
// Slave end: search arbitration, scratchpad commands and busy reporting
// Summary of operation
// [RULE_01] Search bit: send, send inverse, master writes
// [RULE_02] First read slot drives identity bit
// [RULE_03] Second read slot drives inverted bit
// [RULE_04] Mismatching written bit drops slave out
// [RULE_05] Master decodes the two sampled bits
// [RULE_06] Pass starts with reset, presence, search
// [RULE_07] Identity sent least significant bit first
// [RULE_08] Pass covers all 64 bits
// [RULE_09] Write command, page, bytes from byte 0
// [RULE_10] Up to eight bytes, reset abandons
// [RULE_11] Read command returns page from byte 0
// [RULE_12] Eight bytes, then check byte, then ones
// [RULE_13] Reset stops a read
// [RULE_14] Copy moves scratchpad page to storage
// [RULE_15] Copy busy flag high during copy
// [RULE_16] Read slots show copy progress
// [RULE_17] Recall loads storage into scratchpad
// [RULE_18] Convert starts, busy flag while running
// [RULE_19] Read slots show conversion progress
// [RULE_20] Reset, addressing, then memory command
// [RULE_21] Page above seven ignored until reset
`timescale 1ns/1ns
module search_and_scratchpad_cmds #(
	parameter int unsigned COPY_CYCLES = swire_pkg::COPY_CYC,
	parameter int unsigned TEMP_CYCLES = swire_pkg::TEMP_CYC,
	parameter logic [63:0] ROM_ID = swire_pkg::ROM_ID_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	swire_if.device link,
	output logic copy_busy_flag,
	output logic temp_busy_flag
);

	////////////////////////////////////////////////////////////////////
	// State
	swire_pkg::dev_state_t state, next_state; // Command sequencer
	logic [3:0] cnt, next_cnt; // Cycle within the current slot
	logic [2:0] bit_cnt, next_bit_cnt; // Bit within a byte
	logic [7:0] shift, next_shift; // Received byte, LSB first
	logic [7:0] cmd, next_cmd; // Memory command awaiting a page
	logic [2:0] page, next_page; // Selected page
	logic [3:0] byte_idx, next_byte_idx; // Byte position in a page
	logic [5:0] srch_idx, next_srch_idx; // Identity bit under search
	logic [1:0] srch_ph, next_srch_ph; // Step of the three-slot exchange
	logic [7:0] crc, next_crc; // Running check over bytes sent
	logic oe_n, next_oe_n; // Line pull-down enable, low drives
	logic next_copy_busy, next_temp_busy;
	localparam int BUSY_W_L = swire_pkg::BUSY_W; // Busy counter width
	logic [BUSY_W_L-1:0] copy_cnt, next_copy_cnt; // Copy time left
	logic [BUSY_W_L-1:0] temp_cnt, next_temp_cnt; // Conversion time left
	logic [7:0] scratch [64]; // Scratchpad, eight pages of eight
	logic [7:0] store [64]; // Backing memory pages
	logic [7:0] next_scratch [64];
	logic [7:0] next_store [64];

	// Strobes from the sequencer to memory and timers
	logic wr_go, copy_go, recall_go, temp_go;
	logic [7:0] byte_in; // Byte completed by this write slot
	logic [7:0] cur_byte; // Byte being returned on reads
	logic drv_bit; // Level this slave shows in a read slot
	logic at_sample; // Sampling cycle of a slot

	////////////////////////////////////////////////////////////////////
	// Read data and line level selection
	always_comb begin
		at_sample = link.slot_active && (cnt == swire_pkg::SLOT_SAMPLE);
		byte_in = {link.line, shift[7:1]};
		// [RULE_12] data, check byte, ones
		if (byte_idx < swire_pkg::BYTE_CRC) begin
			cur_byte = scratch[{page, byte_idx[2:0]}];
		end else if (byte_idx == swire_pkg::BYTE_CRC) begin
			cur_byte = crc;
		end else begin
			cur_byte = 8'hff;
		end
		case (state)
			swire_pkg::ST_SEARCH: begin
				// [RULE_02] [RULE_03] [RULE_07] bit then inverse, LSB first
				if (srch_ph == 2'h0) begin
					drv_bit = ROM_ID[srch_idx];
				end else if (srch_ph == 2'h1) begin
					drv_bit = ~ROM_ID[srch_idx];
				end else begin
					drv_bit = 1'b1;
				end
			end
			swire_pkg::ST_READ: drv_bit = cur_byte[bit_cnt];
			// [RULE_16] zero while copying
			swire_pkg::ST_COPY_RD: drv_bit = ~copy_busy_flag;
			// [RULE_19] zero while converting
			swire_pkg::ST_TEMP_RD: drv_bit = ~temp_busy_flag;
			default: drv_bit = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_cmd = cmd;
		next_page = page;
		next_byte_idx = byte_idx;
		next_srch_idx = srch_idx;
		next_srch_ph = srch_ph;
		next_crc = crc;
		next_oe_n = oe_n;
		wr_go = 1'b0;
		copy_go = 1'b0;
		recall_go = 1'b0;
		temp_go = 1'b0;
		next_cnt = link.slot_active ? cnt + 4'h1 : 4'h0;
		// Drive is registered, so it is decided one cycle early
		if (link.slot_active && cnt == swire_pkg::SLOT_LAST) begin
			next_oe_n = 1'b1;
		end else if (link.slot_active && cnt == 4'h0
			&& link.slot_kind == swire_pkg::KIND_READ && !drv_bit) begin
			next_oe_n = 1'b0;
		end else if (link.slot_active && cnt == swire_pkg::SLOT_MID
			&& link.slot_kind == swire_pkg::KIND_RESET) begin
			// Presence after the master lets go
			next_oe_n = 1'b0;
		end
		if (at_sample && link.slot_kind == swire_pkg::KIND_RESET) begin
			// [RULE_06] [RULE_10] [RULE_13] [RULE_20] reset restarts
			next_state = swire_pkg::ST_ROM_CMD;
			next_bit_cnt = 3'h0;
		end else if (at_sample && link.slot_kind == swire_pkg::KIND_WRITE) begin
			if (state == swire_pkg::ST_SEARCH) begin
				if (srch_ph == 2'h2) begin
					next_srch_ph = 2'h0;
					next_srch_idx = srch_idx + 6'h1;
					// [RULE_04] drop out on mismatch
					if (link.line != ROM_ID[srch_idx]) begin
						next_state = swire_pkg::ST_IDLE;
					end else if (srch_idx == swire_pkg::ID_LAST) begin
						// [RULE_08] identified after the last bit
						next_state = swire_pkg::ST_MEM_CMD;
					end
				end
			end else if (state == swire_pkg::ST_ROM_CMD
				|| state == swire_pkg::ST_MEM_CMD
				|| state == swire_pkg::ST_PAGE
				|| state == swire_pkg::ST_WRITE) begin
				next_shift = byte_in;
				next_bit_cnt = bit_cnt + 3'h1;
				if (bit_cnt == swire_pkg::BYTE_LAST) begin
					case (state)
						swire_pkg::ST_ROM_CMD: begin
							// [RULE_20] addressing comes first
							if (byte_in == swire_pkg::CMD_SEARCH) begin
								// [RULE_01] start three-slot steps
								next_state = swire_pkg::ST_SEARCH;
								next_srch_idx = 6'h0;
								next_srch_ph = 2'h0;
							end else if (byte_in == swire_pkg::CMD_SKIP) begin
								next_state = swire_pkg::ST_MEM_CMD;
							end else begin
								next_state = swire_pkg::ST_IDLE;
							end
						end
						swire_pkg::ST_MEM_CMD: begin
							next_cmd = byte_in;
							if (byte_in == swire_pkg::CMD_CONVERT_T) begin
								// [RULE_18] no page byte follows
								temp_go = 1'b1;
								next_state = swire_pkg::ST_TEMP_RD;
							end else if (byte_in == swire_pkg::CMD_WRITE_SP
								|| byte_in == swire_pkg::CMD_READ_SP
								|| byte_in == swire_pkg::CMD_COPY_SP
								|| byte_in == swire_pkg::CMD_RECALL) begin
								next_state = swire_pkg::ST_PAGE;
							end else begin
								next_state = swire_pkg::ST_IDLE;
							end
						end
						swire_pkg::ST_PAGE: begin
							next_page = byte_in[2:0];
							next_byte_idx = 4'h0;
							next_crc = 8'h00;
							if (byte_in[7:3] != 5'h00) begin
								// [RULE_21] bad page, wait for reset
								next_state = swire_pkg::ST_IDLE;
							end else if (cmd == swire_pkg::CMD_WRITE_SP) begin
								// [RULE_09] writes begin at byte 0
								next_state = swire_pkg::ST_WRITE;
							end else if (cmd == swire_pkg::CMD_READ_SP) begin
								// [RULE_11] reads begin at byte 0
								next_state = swire_pkg::ST_READ;
							end else if (cmd == swire_pkg::CMD_COPY_SP) begin
								copy_go = ~copy_busy_flag;
								next_state = swire_pkg::ST_COPY_RD;
							end else begin
								recall_go = 1'b1;
								next_state = swire_pkg::ST_IDLE;
							end
						end
						default: begin
							// [RULE_10] store, stop after eight bytes
							wr_go = 1'b1;
							next_byte_idx = byte_idx + 4'h1;
							if (byte_idx[2:0] == swire_pkg::BYTE_LAST) begin
								next_state = swire_pkg::ST_IDLE;
							end
						end
					endcase
				end
			end
		end else if (at_sample && link.slot_kind == swire_pkg::KIND_READ) begin
			if (state == swire_pkg::ST_SEARCH && srch_ph != 2'h2) begin
				next_srch_ph = srch_ph + 2'h1;
			end else if (state == swire_pkg::ST_READ) begin
				next_bit_cnt = bit_cnt + 3'h1;
				if (byte_idx < swire_pkg::BYTE_CRC) begin
					next_crc = {1'b0, crc[7:1]}
						^ ((crc[0] ^ drv_bit) ? swire_pkg::CRC_POLY : 8'h00);
				end
				if (bit_cnt == swire_pkg::BYTE_LAST
					&& byte_idx != swire_pkg::BYTE_ONES) begin
					next_byte_idx = byte_idx + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Memory and busy timers next values
	always_comb begin
		next_scratch = scratch;
		next_store = store;
		next_copy_busy = copy_busy_flag;
		next_copy_cnt = copy_cnt;
		next_temp_busy = temp_busy_flag;
		next_temp_cnt = temp_cnt;
		if (wr_go) begin
			next_scratch[{page, byte_idx[2:0]}] = byte_in;
		end
		// Whole page moves at once; the busy time follows it
		for (int i = 0; i < 8; i++) begin
			if (copy_go) begin
				// [RULE_14] scratchpad into storage
				next_store[{next_page, 3'(i)}] = scratch[{next_page, 3'(i)}];
			end
			if (recall_go) begin
				// [RULE_17] storage into scratchpad
				next_scratch[{next_page, 3'(i)}] = store[{next_page, 3'(i)}];
			end
		end
		// [RULE_15] copy flag high until time runs out
		if (copy_go) begin
			next_copy_busy = 1'b1;
			next_copy_cnt = BUSY_W_L'(COPY_CYCLES);
		end else if (copy_busy_flag) begin
			next_copy_cnt = copy_cnt - 1'b1;
			next_copy_busy = (copy_cnt > 1);
		end
		// [RULE_18] conversion flag; a second start while busy is ignored
		if (temp_go && !temp_busy_flag) begin
			next_temp_busy = 1'b1;
			next_temp_cnt = BUSY_W_L'(TEMP_CYCLES);
		end else if (temp_busy_flag) begin
			next_temp_cnt = temp_cnt - 1'b1;
			next_temp_busy = (temp_cnt > 1);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers, frozen while ce is low
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= swire_pkg::ST_IDLE;
			cnt <= 4'h0;
			bit_cnt <= 3'h0;
			shift <= 8'h00;
			cmd <= 8'h00;
			page <= 3'h0;
			byte_idx <= 4'h0;
			srch_idx <= 6'h0;
			srch_ph <= 2'h0;
			crc <= 8'h00;
			oe_n <= 1'b1;
			copy_busy_flag <= 1'b0;
			copy_cnt <= '0;
			temp_busy_flag <= 1'b0;
			temp_cnt <= '0;
			for (int i = 0; i < 64; i++) begin
				scratch[i] <= 8'h00;
				store[i] <= 8'h00;
			end
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			cmd <= next_cmd;
			page <= next_page;
			byte_idx <= next_byte_idx;
			srch_idx <= next_srch_idx;
			srch_ph <= next_srch_ph;
			crc <= next_crc;
			oe_n <= next_oe_n;
			copy_busy_flag <= next_copy_busy;
			copy_cnt <= next_copy_cnt;
			temp_busy_flag <= next_temp_busy;
			temp_cnt <= next_temp_cnt;
			scratch <= next_scratch;
			store <= next_store;
		end
	end

	// Open-drain output value is always low
	assign link.dev_o = 1'b0;
	assign link.dev_oe_n = oe_n;

endmodule

// *** rtl/swire_master.sv ***
// Master end: frames reset, byte and search-step slots on the link
`timescale 1ns/1ns
module swire_master (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	swire_if.master link,
	input wire logic req_valid,
	input wire logic [1:0] req_op,
	input wire logic [7:0] req_data,
	output logic req_ready,
	output logic resp_valid,
	output logic [7:0] resp_data
);

	////////////////////////////////////////////////////////////////////
	// State
	swire_pkg::mst_state_t state, next_state; // Slot sequencer
	logic [1:0] op, next_op; // Operation in progress
	logic [7:0] shift, next_shift; // Byte out or in, LSB first
	logic [3:0] rem, next_rem; // Slots left in the operation
	logic [3:0] cnt, next_cnt; // Cycle within the slot
	logic rd0, next_rd0; // First sample, or presence
	logic rd1, next_rd1; // Second sample of a search step
	logic dir, next_dir; // Chosen search bit
	logic none, next_none; // No slave answered a search step
	logic active, next_active;
	logic [1:0] kind, next_kind;
	logic oe_n, next_oe_n;
	logic next_ready, next_resp_valid;
	logic [7:0] next_resp_data;
	logic go; // Start a slot next cycle
	logic wbit; // Bit to write in that slot

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_state = state;
		next_op = op;
		next_shift = shift;
		next_rem = rem;
		next_cnt = cnt;
		next_rd0 = rd0;
		next_rd1 = rd1;
		next_dir = dir;
		next_none = none;
		next_active = active;
		next_kind = kind;
		next_oe_n = oe_n;
		next_ready = req_ready;
		next_resp_valid = 1'b0;
		next_resp_data = resp_data;
		go = 1'b0;
		wbit = 1'b1;
		case (state)
			swire_pkg::M_IDLE: begin
				if (req_valid) begin
					next_op = req_op;
					next_shift = req_data;
					next_dir = req_data[0];
					next_none = 1'b0;
					next_ready = 1'b0;
					go = 1'b1;
					if (req_op == swire_pkg::OP_RESET) begin
						next_rem = swire_pkg::SLOTS_ONE;
					end else if (req_op == swire_pkg::OP_TRIPLET) begin
						next_rem = swire_pkg::SLOTS_TRIPLET;
					end else begin
						next_rem = swire_pkg::SLOTS_BYTE;
					end
				end
			end
			swire_pkg::M_SLOT: begin
				if (cnt == swire_pkg::SLOT_SAMPLE) begin
					if (op == swire_pkg::OP_RESET) begin
						// [RULE_06] presence seen as a low line
						next_rd0 = ~link.line;
					end else if (op == swire_pkg::OP_READ) begin
						next_shift = {link.line, shift[7:1]};
					end else if (op == swire_pkg::OP_WRITE) begin
						next_shift = {1'b0, shift[7:1]};
					end else if (rem == swire_pkg::SLOTS_TRIPLET) begin
						next_rd0 = link.line;
					end else if (rem == 4'h2) begin
						next_rd1 = link.line;
						// [RULE_05] both high: nobody is there
						next_none = rd0 & link.line;
					end
				end
				if (cnt == swire_pkg::SLOT_MID && kind == swire_pkg::KIND_RESET) begin
					next_oe_n = 1'b1;
				end
				if (cnt == swire_pkg::SLOT_LAST) begin
					next_active = 1'b0;
					next_oe_n = 1'b1;
					next_rem = rem - 4'h1;
					next_state = swire_pkg::M_GAP;
				end else begin
					next_cnt = cnt + 4'h1;
				end
			end
			default: begin
				if (rem == 4'h0 || none) begin
					next_state = swire_pkg::M_IDLE;
					next_ready = 1'b1;
					next_resp_valid = 1'b1;
					if (op == swire_pkg::OP_RESET) begin
						next_resp_data = {7'h00, rd0};
					end else if (op == swire_pkg::OP_TRIPLET) begin
						next_resp_data = {4'h0, none, dir, rd1, rd0};
					end else begin
						next_resp_data = shift;
					end
				end else begin
					go = 1'b1;
				end
			end
		endcase
		if (go) begin
			next_state = swire_pkg::M_SLOT;
			next_cnt = 4'h0;
			next_active = 1'b1;
			if (next_op == swire_pkg::OP_RESET) begin
				next_kind = swire_pkg::KIND_RESET;
			end else if (next_op == swire_pkg::OP_WRITE) begin
				next_kind = swire_pkg::KIND_WRITE;
				wbit = next_shift[0];
			end else if (next_op == swire_pkg::OP_READ) begin
				next_kind = swire_pkg::KIND_READ;
			end else if (next_rem == swire_pkg::SLOTS_ONE) begin
				// [RULE_01] [RULE_05] third slot writes the chosen bit
				next_kind = swire_pkg::KIND_WRITE;
				wbit = (rd0 != rd1) ? rd0 : dir;
				next_dir = wbit;
			end else begin
				next_kind = swire_pkg::KIND_READ;
			end
			// Reset and write-zero pull the line from the first cycle
			next_oe_n = !((next_kind == swire_pkg::KIND_RESET)
				|| (next_kind == swire_pkg::KIND_WRITE && !wbit));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers, frozen while ce is low
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= swire_pkg::M_IDLE;
			op <= swire_pkg::OP_RESET;
			shift <= 8'h00;
			rem <= 4'h0;
			cnt <= 4'h0;
			rd0 <= 1'b0;
			rd1 <= 1'b0;
			dir <= 1'b0;
			none <= 1'b0;
			active <= 1'b0;
			kind <= swire_pkg::KIND_RESET;
			oe_n <= 1'b1;
			req_ready <= 1'b1;
			resp_valid <= 1'b0;
			resp_data <= 8'h00;
		end else if (ce) begin
			state <= next_state;
			op <= next_op;
			shift <= next_shift;
			rem <= next_rem;
			cnt <= next_cnt;
			rd0 <= next_rd0;
			rd1 <= next_rd1;
			dir <= next_dir;
			none <= next_none;
			active <= next_active;
			kind <= next_kind;
			oe_n <= next_oe_n;
			req_ready <= next_ready;
			resp_valid <= next_resp_valid;
			resp_data <= next_resp_data;
		end
	end

	assign link.slot_active = active;
	assign link.slot_kind = kind;
	assign link.mst_o = 1'b0;
	assign link.mst_oe_n = oe_n;

endmodule

// *** tb/swire_checker.sv ***
// Slot-level checks on the link joining master and slave
`timescale 1ns/1ns
module swire_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic slot_active,
	input wire logic [1:0] slot_kind,
	input wire logic mst_o,
	input wire logic mst_oe_n,
	input wire logic dev_o,
	input wire logic dev_oe_n,
	input wire logic line
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [3:0] k; // Cycle index inside the slot
	logic [3:0] next_k;
	logic [1:0] smp; // Line at sample point, last two slots
	logic [1:0] next_smp;
	logic [3:0] kinds; // Kinds of the last two slots
	logic [3:0] next_kinds;
	// Slot start of one kind
	sequence s_go(logic [1:0] kd);
		$rose(slot_active) && slot_kind == kd;
	endsequence
	////////////////////////////////////////////////////////////////////////
	// Track slot position and what the master sampled
	always_comb begin
		next_k = slot_active ? k + 4'h1 : 4'h0;
		next_smp = smp;
		next_kinds = kinds;
		if (slot_active && k == swire_pkg::SLOT_SAMPLE) begin
			next_smp = {smp[0], line};
			next_kinds = {kinds[1:0], slot_kind};
		end
	end
	// Register the tracking state
	always_ff @(posedge clk) begin
		if (reset) begin
			k <= 4'h0;
			smp <= 2'h0;
			kinds <= 4'h0;
		end else begin
			k <= next_k;
			smp <= next_smp;
			kinds <= next_kinds;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// presence window
	AST_PRESENCE: assert property (
		s_go(swire_pkg::KIND_RESET) |-> dev_oe_n [*4] ##1 !dev_oe_n [*4])
		else $error("presence pulse misplaced");
	AST_MST_RESET: assert property (
		s_go(swire_pkg::KIND_RESET) |-> !mst_oe_n [*4] ##1 mst_oe_n [*4])
		else $error("reset pulse misplaced");
	AST_SLOT_LEN: assert property (
		$rose(slot_active) |-> slot_active [*8] ##1 !slot_active)
		else $error("slot length wrong");
	AST_KIND_STABLE: assert property (
		slot_active && $past(slot_active) |-> $stable(slot_kind))
		else $error("slot kind changed inside slot");
	AST_WRITE_QUIET: assert property (
		slot_active && slot_kind == swire_pkg::KIND_WRITE |-> dev_oe_n)
		else $error("slave drove a write slot");
	AST_IDLE_HIGH: assert property (
		!slot_active |-> dev_oe_n && line)
		else $error("line not released between slots");
	AST_READ_HOLD: assert property (
		s_go(swire_pkg::KIND_READ) |-> dev_oe_n ##2 $stable(dev_oe_n) [*6])
		else $error("read bit not held through slot");
	AST_SEARCH_INV: assert property (
		$rose(slot_active) && slot_kind == swire_pkg::KIND_WRITE
		&& kinds == {swire_pkg::KIND_READ, swire_pkg::KIND_READ}
		|-> smp[1] != smp[0])
		else $error("second search bit not the inverse");
	// Main scenarios
	COV_WRITE: cover property (s_go(swire_pkg::KIND_WRITE));
	COV_READ_ZERO: cover property (s_go(swire_pkg::KIND_READ) ##1 !dev_oe_n);
	COV_TRIPLET: cover property ($rose(slot_active)
		&& kinds == {swire_pkg::KIND_READ, swire_pkg::KIND_READ});
endmodule

// *** tb/testbench.sv ***
// Self-checking bench joining both ends across the link
`timescale 1ns/1ns
module testbench;
	localparam int unsigned BUSY_CYC = 20; // Shortened busy times
	// Arbitrary identity value
	localparam logic [63:0] ID_VAL = 64'h3c96_a50f_18e7_d24b;
	localparam logic [7:0] PG = 8'h07; // Page under test, top boundary
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1; // Clock enable, dropped once to test freezing
	logic req_valid = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic [7:0] req_data = 8'h00;
	logic req_ready;
	logic resp_valid;
	logic [7:0] resp_data;
	logic copy_busy_flag;
	logic temp_busy_flag;
	logic [7:0] r; // Last response
	int fail_count = 0;
	int n_tests = 0;
	swire_if link();
	search_and_scratchpad_cmds #(.COPY_CYCLES(BUSY_CYC),
		.TEMP_CYCLES(BUSY_CYC), .ROM_ID(ID_VAL)) i_search_and_scratchpad_cmds (
		.clk(clk), .reset(reset), .ce(ce), .link(link.device),
		.copy_busy_flag(copy_busy_flag), .temp_busy_flag(temp_busy_flag));
	swire_master i_swire_master (.clk(clk), .reset(reset), .ce(ce),
		.link(link.master), .req_valid(req_valid), .req_op(req_op),
		.req_data(req_data), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp_data(resp_data));
	swire_checker i_swire_checker (.clk(clk), .reset(reset),
		.slot_active(link.slot_active), .slot_kind(link.slot_kind),
		.mst_o(link.mst_o), .mst_oe_n(link.mst_oe_n), .dev_o(link.dev_o),
		.dev_oe_n(link.dev_oe_n), .line(link.line));
	// Clock, 20 ns period
	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Byte comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One user operation, entered and left at a falling edge
	task automatic op(input logic [1:0] o, input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		req_op = o;
		req_data = d;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		while (resp_valid !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, resp_valid}, 8'h01);
		r = resp_data;
	endtask
	// Reset, skip addressing, memory command and page
	task automatic start(input logic [7:0] cmd, input logic [7:0] pg);
		op(swire_pkg::OP_RESET, 8'h00);
		chk(r & 8'h01, 8'h01);
		op(swire_pkg::OP_WRITE, swire_pkg::CMD_SKIP);
		op(swire_pkg::OP_WRITE, cmd);
		op(swire_pkg::OP_WRITE, pg);
	endtask
	// Read one byte and compare
	task automatic rd(input logic [7:0] exp);
		op(swire_pkg::OP_READ, 8'h00);
		chk(r, exp);
	endtask
	// Reflected check byte over one more byte
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] b);
		logic [7:0] x;
		x = c;
		for (int i = 0; i < 8; i++) begin
			x = (x[0] ^ b[i]) ? ((x >> 1) ^ swire_pkg::CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction
	// Write eight bytes base+i into a page
	task automatic wr_page(input logic [7:0] pg, input logic [7:0] base);
		start(swire_pkg::CMD_WRITE_SP, pg);
		for (int i = 0; i < 8; i++) begin
			op(swire_pkg::OP_WRITE, base + 8'(i));
		end
	endtask
	// Read whole page, check byte, then ones
	task automatic rd_page(input logic [7:0] base);
		logic [7:0] c;
		c = 8'h00;
		start(swire_pkg::CMD_READ_SP, PG);
		for (int i = 0; i < 8; i++) begin
			rd(base + 8'(i));
			c = crc8(c, base + 8'(i));
		end
		rd(c);
		rd(8'hff);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		reset = 1'b0;
		// Search pass over all identity bits
		op(swire_pkg::OP_RESET, 8'h00);
		chk(r & 8'h01, 8'h01);
		op(swire_pkg::OP_WRITE, swire_pkg::CMD_SEARCH);
		for (int i = 0; i < 64; i++) begin
			op(swire_pkg::OP_TRIPLET, 8'h00);
			chk(r, {5'h00, ID_VAL[i], ~ID_VAL[i], ID_VAL[i]});
		end
		// Conversion straight after the pass
		op(swire_pkg::OP_WRITE, swire_pkg::CMD_CONVERT_T);
		chk({7'h00, temp_busy_flag}, 8'h01);
		op(swire_pkg::OP_READ, 8'h00);
		chk(r & 8'h81, 8'h80);
		chk({7'h00, temp_busy_flag}, 8'h00);
		// Nine bytes written, ninth must be dropped
		wr_page(PG, 8'ha0);
		op(swire_pkg::OP_WRITE, 8'hee);
		rd_page(8'ha0);
		// Read cut short by reset, then copy
		start(swire_pkg::CMD_READ_SP, PG);
		rd(8'ha0);
		start(swire_pkg::CMD_COPY_SP, PG);
		chk({7'h00, copy_busy_flag}, 8'h01);
		// Clock enable low must freeze the copy time left
		ce = 1'b0;
		repeat (40) @(negedge clk);
		chk({7'h00, copy_busy_flag}, 8'h01);
		ce = 1'b1;
		op(swire_pkg::OP_READ, 8'h00);
		chk(r & 8'h81, 8'h80);
		chk({7'h00, copy_busy_flag}, 8'h00);
		// Overwrite scratchpad, then a bad page must change nothing
		wr_page(PG, 8'h50);
		wr_page(8'h0f, 8'h33);
		op(swire_pkg::OP_TRIPLET, 8'h00);
		chk(r & 8'h0b, 8'h0b);
		rd_page(8'h50);
		// Recall brings back the copied page
		start(swire_pkg::CMD_RECALL, PG);
		rd_page(8'ha0);
		end_of_test();
	end
	// Watchdog: the tests need about 10000 cycles, allow 40000
	initial begin
		#800000;
		fail_count++;
		$display("ERROR at %0t: got %h expected %h", $time, 8'h00, 8'h01);
		end_of_test();
	end
endmodule
